//--- hdl/pdst_defines.vh
// register offsets, field layouts, response codes and slot timing for the
// power-down slot timing block; included by the top design file, the monitor and the bench
`ifndef PDST_DEFINES_VH
`define PDST_DEFINES_VH
`define PDST_IDX_SLOT_LO 8'h1A
`define PDST_IDX_SLOT_HI 8'h1B
`define PDST_IDX_CONV2 8'h1C
// each register is one aligned word: byte address is four times the index
`define PDST_OFF_SLOT_LO (`PDST_IDX_SLOT_LO << 2)
`define PDST_OFF_SLOT_HI (`PDST_IDX_SLOT_HI << 2)
`define PDST_OFF_CONV2 (`PDST_IDX_CONV2 << 2)
`define PDST_OFF_CTRL 8'h20
`define PDST_OFF_STAT 8'h24
`define PDST_CONV2_RAMP_BIT 6
`define PDST_CONV2_CODE_MSB 4
`define PDST_CONV2_RW_MASK 8'h5F
`define PDST_CTRL_PWRDN_BIT 0
`define PDST_CTRL_LOW_POWER_HOLD_STATE_BIT 1
`define PDST_CLK_MHZ 24'h000064
`define PDST_T1_US 24'h0005DC
`define PDST_T2_US 24'h000BB8
`define PDST_T3_US 24'h002710
`define PDST_CYC1 (`PDST_T1_US * `PDST_CLK_MHZ)
`define PDST_CYC2 (`PDST_T2_US * `PDST_CLK_MHZ)
`define PDST_CYC3 (`PDST_T3_US * `PDST_CLK_MHZ)
`define PDST_NUM_SLOTS 8
`define PDST_RESP_OKAY 2'b00
`define PDST_RESP_SLVERR 2'b10
`endif

//--- hdl/pdst_slot_timer.v
// slot timer: counts one slot duration after a start pulse
// assumes start is only given while idle
`timescale 1ns/10ps
`default_nettype none
module pdst_slot_timer #(
   parameter [23:0] CYC1 = 24'd150000,
   parameter [23:0] CYC2 = 24'd300000,
   parameter [23:0] CYC3 = 24'd1000000
) (
   input wire aclk,
   input wire aresetn,
   input wire start,
   input wire [1:0] code,
   output reg done
);
   reg [23:0] cnt_reg;
   reg busy_reg;

   function [23:0] pdst_decode;
      input [1:0] c;
      begin
         case (c)
            2'd1: pdst_decode = CYC1;
            2'd2: pdst_decode = CYC2;
            2'd3: pdst_decode = CYC3;
            default: pdst_decode = 24'h000000;
         endcase
      end
   endfunction

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt_reg <= 24'h000000;
         busy_reg <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (start)
         begin
            // zero code ends at once
            if (code == 2'd0)
               done <= 1'b1;
            else
            begin
               cnt_reg <= pdst_decode(code) - 24'h000001;
               busy_reg <= 1'b1;
            end
         end
         else if (busy_reg)
         begin
            if (cnt_reg == 24'h000001 || cnt_reg == 24'h000000)
            begin
               busy_reg <= 1'b0;
               done <= 1'b1;
            end
            cnt_reg <= cnt_reg - 24'h000001;
         end
      end
   end
endmodule
`default_nettype wire

//--- hdl/pdst_top.v
// power-down slot timing: slot duration registers, second converter
// standby voltage register, AXI4-Lite slave and slot sequencer
// assumes nvm defaults are stable while aresetn is low
//
// What this block does
// - each slot holds a 2-bit code: none, 1.5ms, 3ms, 10ms
// - slots 0-3 sit at 1Ah, slot 0 in bits 7-6 down to slot 3
// - slots 4-7 sit at 1Bh, slot 7 in bits 1-0
// - same slot durations serve power-down and active-to-standby
// - durations load from nvm at reset, then host reads or writes freely
// - bit 6 of 1Ch enables the second converter standby ramp
// - bits 4-0 of 1Ch hold standby code, 0.600V plus 25mV steps
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "pdst_defines.vh"
module pdst_top #(
   parameter [23:0] CYC1 = `PDST_CYC1,
   parameter [23:0] CYC2 = `PDST_CYC2,
   parameter [23:0] CYC3 = `PDST_CYC3
) (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] nvm_slot_lo,
   input wire [7:0] nvm_slot_hi,
   input wire [7:0] nvm_conv2,
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg seq_busy,
   output reg seq_low_power_hold_state,
   output reg [2:0] seq_slot,
   output reg seq_slot_pulse,
   output reg seq_done_pulse,
   output reg conv_two_standby_ramp_en,
   output reg [4:0] conv_two_standby_volt_code,
   output reg conv_two_ramp_req
);
   localparam ST_IDLE = 2'd0;
   localparam ST_START = 2'd1;
   localparam ST_WAIT = 2'd2;

   reg [7:0] shutdown_slot_times_lo_reg;
   reg [7:0] shutdown_slot_times_hi_reg;
   reg [31:0] aw_addr_reg;
   reg aw_have_reg;
   reg [31:0] w_data_reg;
   reg w_strb_reg;
   reg w_have_reg;
   reg [1:0] state_reg;
   reg is_low_power_hold_state_reg;
   reg pend_pwrdn_reg;
   reg pend_low_power_hold_state_reg;
   reg nvm_load_reg;
   wire timer_done;
   wire [1:0] cur_code;
   wire wr_fire;
   wire rd_fire;
   wire [7:0] wa;
   wire [7:0] ra;
   wire wr_ok;

   // per-slot code: slot 0 / slot 4 in the top bit pair
   function [1:0] pdst_slot_code;
      input [2:0] slot;
      input [7:0] lo;
      input [7:0] hi;
      reg [7:0] r;
      begin
         r = slot[2] ? hi : lo;
         case (slot[1:0])
            2'd0: pdst_slot_code = r[7:6];
            2'd1: pdst_slot_code = r[5:4];
            2'd2: pdst_slot_code = r[3:2];
            default: pdst_slot_code = r[1:0];
         endcase
      end
   endfunction

   function pdst_known;
      input [7:0] a;
      begin
         pdst_known = (a == `PDST_OFF_SLOT_LO) || (a == `PDST_OFF_SLOT_HI) ||
            (a == `PDST_OFF_CONV2) || (a == `PDST_OFF_CTRL) || (a == `PDST_OFF_STAT);
      end
   endfunction

   assign cur_code = pdst_slot_code(seq_slot, shutdown_slot_times_lo_reg,
      shutdown_slot_times_hi_reg);
   assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   assign wa = aw_addr_reg[7:0];
   assign ra = s_axi_araddr[7:0];
   assign wr_ok = (aw_addr_reg[31:8] == 24'h000000) && pdst_known(wa);

   pdst_slot_timer #(
      .CYC1(CYC1),
      .CYC2(CYC2),
      .CYC3(CYC3)
   ) u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(state_reg == ST_START),
      .code(cur_code),
      .done(timer_done)
   );

   // nvm defaults are captured on the first edge after reset release
   always @(posedge aclk)
   begin
      if (!aresetn)
         nvm_load_reg <= 1'b1;
      else
         nvm_load_reg <= 1'b0;
   end

   // write channel and register file
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_addr_reg <= 32'h00000000;
         aw_have_reg <= 1'b0;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 1'b0;
         w_have_reg <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PDST_RESP_OKAY;
         shutdown_slot_times_lo_reg <= 8'h00;
         shutdown_slot_times_hi_reg <= 8'h00;
         conv_two_standby_ramp_en <= 1'b0;
         conv_two_standby_volt_code <= 5'h00;
         pend_pwrdn_reg <= 1'b0;
         pend_low_power_hold_state_reg <= 1'b0;
      end
      else
      begin
         if (nvm_load_reg)
         begin
            shutdown_slot_times_lo_reg <= nvm_slot_lo;
            shutdown_slot_times_hi_reg <= nvm_slot_hi;
            conv_two_standby_ramp_en <= nvm_conv2[`PDST_CONV2_RAMP_BIT];
            conv_two_standby_volt_code <= nvm_conv2[`PDST_CONV2_CODE_MSB:0];
         end
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_addr_reg <= s_axi_awaddr;
            aw_have_reg <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb[0];
            w_have_reg <= 1'b1;
         end
         // commands taken by the sequencer clear; a new write wins
         if (state_reg == ST_IDLE && (pend_pwrdn_reg || pend_low_power_hold_state_reg))
         begin
            pend_pwrdn_reg <= 1'b0;
            pend_low_power_hold_state_reg <= 1'b0;
         end
         if (wr_fire)
         begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `PDST_RESP_OKAY : `PDST_RESP_SLVERR;
            if (wr_ok && w_strb_reg)
            begin
               case (wa)
                  `PDST_OFF_SLOT_LO: shutdown_slot_times_lo_reg <= w_data_reg[7:0];
                  `PDST_OFF_SLOT_HI: shutdown_slot_times_hi_reg <= w_data_reg[7:0];
                  `PDST_OFF_CONV2:
                  begin
                     conv_two_standby_ramp_en <= w_data_reg[`PDST_CONV2_RAMP_BIT];
                     conv_two_standby_volt_code <= w_data_reg[`PDST_CONV2_CODE_MSB:0];
                  end
                  `PDST_OFF_CTRL:
                  begin
                     if (w_data_reg[`PDST_CTRL_PWRDN_BIT])
                        pend_pwrdn_reg <= 1'b1;
                     if (w_data_reg[`PDST_CTRL_LOW_POWER_HOLD_STATE_BIT])
                        pend_low_power_hold_state_reg <= 1'b1;
                  end
                  default: ;
               endcase
            end
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // read channel
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `PDST_RESP_OKAY;
      end
      else if (rd_fire)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= (s_axi_araddr[31:8] == 24'h000000 && pdst_known(ra)) ?
            `PDST_RESP_OKAY : `PDST_RESP_SLVERR;
         case (ra)
            `PDST_OFF_SLOT_LO: s_axi_rdata <= {24'h000000, shutdown_slot_times_lo_reg};
            `PDST_OFF_SLOT_HI: s_axi_rdata <= {24'h000000, shutdown_slot_times_hi_reg};
            // reserved bits 7 and 5 read zero
            `PDST_OFF_CONV2: s_axi_rdata <= {24'h000000, 1'b0, conv_two_standby_ramp_en,
               1'b0, conv_two_standby_volt_code};
            `PDST_OFF_STAT: s_axi_rdata <= {24'h000000, 2'b00, seq_slot, 1'b0,
               seq_low_power_hold_state, seq_busy};
            default: s_axi_rdata <= 32'h00000000;
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // slot sequencer, shared by both sequence kinds
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_reg <= ST_IDLE;
         is_low_power_hold_state_reg <= 1'b0;
         seq_busy <= 1'b0;
         seq_slot <= 3'd0;
         seq_slot_pulse <= 1'b0;
         seq_done_pulse <= 1'b0;
         seq_low_power_hold_state <= 1'b0;
         conv_two_ramp_req <= 1'b0;
      end
      else
      begin
         seq_slot_pulse <= 1'b0;
         seq_done_pulse <= 1'b0;
         case (state_reg)
            ST_IDLE:
               if (pend_pwrdn_reg || pend_low_power_hold_state_reg)
               begin
                  is_low_power_hold_state_reg <= !pend_pwrdn_reg;
                  seq_busy <= 1'b1;
                  seq_slot <= 3'd0;
                  seq_slot_pulse <= 1'b1;
                  seq_low_power_hold_state <= 1'b0;
                  conv_two_ramp_req <= 1'b0;
                  state_reg <= ST_START;
               end
            ST_START:
               state_reg <= ST_WAIT;
            ST_WAIT:
               if (timer_done)
               begin
                  if (seq_slot == 3'd7)
                  begin
                     seq_busy <= 1'b0;
                     seq_done_pulse <= 1'b1;
                     seq_low_power_hold_state <= is_low_power_hold_state_reg;
                     conv_two_ramp_req <= is_low_power_hold_state_reg && conv_two_standby_ramp_en;
                     state_reg <= ST_IDLE;
                  end
                  else
                  begin
                     seq_slot <= seq_slot + 3'd1;
                     seq_slot_pulse <= 1'b1;
                     state_reg <= ST_START;
                  end
               end
            default:
               state_reg <= ST_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

//--- test/pdst_host_model.sv
// host model: AXI4-Lite master, one write and one read at a time
// ready and valid are sampled mid-cycle, stable up to the next edge
`timescale 1ns/10ps
`default_nettype none
module pdst_host_model (
   input wire logic aclk,
   output logic [31:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   output logic [31:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
   task automatic wr(input logic [31:0] a, input logic [7:0] d, output logic [1:0] r);
      logic ah, wh, bh;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, d};
      wstrb <= 4'hF;
      {awvalid, wvalid, bready} <= 3'h7;
      bh = 1'h0;
      while (!bh)
      begin
         @(negedge aclk);
         ah = awvalid && awready;
         wh = wvalid && wready;
         bh = bvalid;
         r = bresp;
         @(posedge aclk);
         if (ah) awvalid <= 1'h0;
         if (wh) wvalid <= 1'h0;
      end
      bready <= 1'h0;
   endtask
   task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ah, rh;
      @(posedge aclk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      rh = 1'h0;
      while (!rh)
      begin
         @(negedge aclk);
         ah = arvalid && arready;
         rh = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ah) arvalid <= 1'h0;
      end
      rready <= 1'h0;
   endtask
endmodule
`default_nettype wire

//--- test/pdst_top_monitor.sv
// checker on the pdst_top ports
// bound into every pdst_top instance
`timescale 1ns/10ps
`default_nettype none
`include "pdst_defines.vh"
module pdst_top_monitor (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic seq_busy,
   input wire logic seq_low_power_hold_state,
   input wire logic [2:0] seq_slot,
   input wire logic seq_slot_pulse,
   input wire logic seq_done_pulse,
   input wire logic conv_two_standby_ramp_en,
   input wire logic conv_two_ramp_req
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   a_pulse_busy: assert property (seq_slot_pulse |-> seq_busy)
      else $error("slot pulse while idle");
   a_slot_step: assert property ($changed(seq_slot) && seq_busy |->
      seq_slot == $past(seq_slot) + 3'h1) else $error("slot skipped");
   a_done_last: assert property (seq_done_pulse |-> seq_slot == 3'h7)
      else $error("done before last slot");
   a_ramp_cause: assert property ($rose(conv_two_ramp_req) |-> conv_two_standby_ramp_en)
      else $error("ramp without enable");
   a_start_clear: assert property ($rose(seq_busy) |-> ##[0:2]
      !seq_low_power_hold_state && !conv_two_ramp_req) else $error("state not cleared");
   c_done: cover property (seq_done_pulse);
   c_ramp: cover property ($rose(conv_two_ramp_req));
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `PDST_RESP_SLVERR);
endmodule
bind pdst_top pdst_top_monitor i_pdst_top_monitor (.*);
`default_nettype wire

//--- test/pdst_top_tb.sv
// self-checking bench for pdst_top with shortened slot counts
// host model drives the register bus, nvm defaults are random
`timescale 1ns/10ps
`default_nettype none
`include "pdst_defines.vh"
module pdst_top_tb;
   localparam int C1 = 5, C2 = 10, C3 = 20;
   logic aclk, aresetn;
   logic [7:0] nvm [3], ex [3], cfg [3];
   wire [31:0] awaddr, wdata, araddr, rdata;
   wire [3:0] wstrb;
   wire [1:0] bresp, rresp;
   wire awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   wire busy, hold, spulse, dpulse, ramp_en, ramp_req;
   wire [2:0] slot;
   wire [4:0] vcode;
   int bad_count = 0, check_count = 0, cyc = 0, ts [9], i;
   logic [31:0] d;
   logic [1:0] r;
   pdst_top #(.CYC1(24'h5), .CYC2(24'hA), .CYC3(24'h14)) i_pdst_top (
      .aclk(aclk), .aresetn(aresetn), .nvm_slot_lo(nvm[0]), .nvm_slot_hi(nvm[1]),
      .nvm_conv2(nvm[2]), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .seq_busy(busy), .seq_low_power_hold_state(hold), .seq_slot(slot),
      .seq_slot_pulse(spulse), .seq_done_pulse(dpulse), .conv_two_standby_ramp_en(ramp_en),
      .conv_two_standby_volt_code(vcode), .conv_two_ramp_req(ramp_req));
   pdst_host_model i_pdst_host_model (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   initial
   begin
      aclk = 1'h0;
      forever #5 aclk = ~aclk;
   end
   task chk(input logic [33:0] got, input logic [33:0] exp);
      check_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task report_and_stop;
      $display("checks=%0d mismatches=%0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (spulse) ts[slot] <= cyc;
      if (dpulse) ts[8] <= cyc;
      if (cyc == 20000)
      begin
         bad_count++;
         report_and_stop;
      end
   end
   // writable bits of the standby voltage register: ramp enable and code
   function automatic logic [7:0] keep(input int k, input logic [7:0] x);
      return (k == 2) ? (x & 8'h5F) : x;
   endfunction
   function automatic logic [31:0] reg_addr(input int k);
      return (`PDST_IDX_SLOT_LO + k) * 4;
   endfunction
   function automatic int dur(input int s);
      int c;
      c = ({cfg[0], cfg[1]} >> (14 - 2 * s)) & 3;
      return c == 0 ? 0 : c == 1 ? C1 : c == 2 ? C2 : C3;
   endfunction
   task run_seq(input logic [7:0] cmd, input logic [1:0] st);
      int n;
      for (n = 0; n < 3; n++) i_pdst_host_model.wr(reg_addr(n), cfg[n], r);
      i_pdst_host_model.wr(32'h20, cmd, r);
      n = 0;
      while (dpulse !== 1'h1 && n < 2000)
      begin
         @(negedge aclk);
         n++;
      end
      chk(n < 2000, 1);
      @(negedge aclk);
      for (int s = 0; s < 8; s++)
      begin
         n = ts[s + 1] - ts[s] - dur(s);
         chk(n >= 0 && n <= 4, 1);
      end
      chk({hold, ramp_req}, st);
      chk(busy, 1'h0);
      i_pdst_host_model.rd(`PDST_OFF_STAT, d, r);
      chk(d, {24'h0, 2'h0, 3'h7, 1'h0, st[1], 1'h0});
   endtask
   initial
   begin
      void'($urandom(32'h2C2F950E));
      aresetn <= 1'h0;
      for (i = 0; i < 3; i++) nvm[i] <= 8'($urandom);
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (2) @(posedge aclk);
      for (i = 0; i < 3; i++)
      begin
         ex[i] = keep(i, nvm[i]);
         i_pdst_host_model.rd(reg_addr(i), d, r);
         chk(d, ex[i]);
         chk(r, `PDST_RESP_OKAY);
      end
      for (int k = 0; k < 14; k++)
      begin
         i = (k < 2) ? 2 : $urandom_range(2);
         d = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : $urandom;
         i_pdst_host_model.wr(reg_addr(i), d[7:0], r);
         chk(r, `PDST_RESP_OKAY);
         ex[i] = keep(i, d[7:0]);
         i_pdst_host_model.rd(reg_addr(i), d, r);
         chk(d, ex[i]);
         chk(r, `PDST_RESP_OKAY);
         chk({ramp_en, vcode}, {ex[2][6], ex[2][4:0]});
      end
      i_pdst_host_model.wr(32'h30, 8'h55, r);
      chk(r, `PDST_RESP_SLVERR);
      i_pdst_host_model.wr(32'h1A, 8'h55, r);
      chk(r, `PDST_RESP_SLVERR);
      i_pdst_host_model.rd(32'h130, d, r);
      chk(d, 32'h0);
      chk(r, `PDST_RESP_SLVERR);
      cfg = '{8'h1B, 8'hE4, 8'h40};
      run_seq(8'h02, 2'h3);
      run_seq(8'h01, 2'h0);
      cfg = '{$urandom, $urandom, 8'h1F};
      run_seq(8'h02, 2'h2);
      report_and_stop;
   end
endmodule
`default_nettype wire
